// ===== obd_defs.svh
// option byte decoder offsets, field positions and reset values
`ifndef OBD_DEFS_SVH
`define OBD_DEFS_SVH
// register indices; byte address is four times the index
`define OBD_IDX_OPT_A   2'h0
`define OBD_IDX_OPT_B   2'h1
`define OBD_IDX_CTRL    2'h2
`define OBD_IDX_STAT    2'h3
// flash program memory addresses of the option bytes
`define OBD_FA_W        15
`define OBD_FADDR_A     15'h0000
`define OBD_FADDR_B     15'h0001
// fields of option byte a
`define OBD_B_ACTION    7
`define OBD_B_ALWAYS_ON 6
`define OBD_B_OSC_HI    5
`define OBD_B_OSC_LO    4
`define OBD_B_BO_KEEP   3
`define OBD_B_RD_PROT   2
`define OBD_B_RSVD      1
`define OBD_B_WR_PERMIT 0
// control register bits
`define OBD_C_WDT_START 0
`define OBD_C_RELOAD    1
// erased flash value
`define OBD_ERASED      8'hff
`define OBD_RESP_OKAY   2'h0
`define OBD_RESP_SLVERR 2'h2
`endif

// ===== obd_pkg.sv
// option byte decoder types
package obd_pkg;
`include "obd_defs.svh"
  typedef enum logic [3:0] {
    OBD_RD_A = 4'b0001,
    OBD_RD_B = 4'b0010,
    OBD_WAIT = 4'b0100,
    OBD_RUN  = 4'b1000
  } obd_fsm_type;

  typedef struct packed {
    logic [1:0]            osc;
    logic                  bo_en;
    logic                  code_acc;
    logic                  dbg_full;
  } obd_cfg_type;

  typedef struct packed {
    obd_fsm_type           st;
    logic [7:0]            opt_a;
    logic [7:0]            opt_b;
    obd_cfg_type           cfg;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic                  frd;
    logic [`OBD_FA_W-1:0]  faddr;
    logic                  prog;
    logic [`OBD_FA_W-1:0]  paddr;
    logic [7:0]            pdata;
    logic                  wdt_en;
    logic                  irq;
    logic                  ack;
    logic                  srst;
    logic                  ugrant;
    logic                  umass;
    logic                  dmass;
    logic                  run;
  } obd_state_type;
endpackage

// ===== obd_option_byte_decoder.sv
// option byte loader, decoder and watchdog policy with axi4-lite access
`timescale 1ns/1ps
`include "obd_defs.svh"
module obd_option_byte_decoder
  import obd_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 ce_in,
  input  wire logic [3:0]           s_axi_awaddr_in,
  input  wire logic                 s_axi_awvalid_in,
  output logic                      s_axi_awready_out,
  input  wire logic [31:0]          s_axi_wdata_in,
  input  wire logic [3:0]           s_axi_wstrb_in,
  input  wire logic                 s_axi_wvalid_in,
  output logic                      s_axi_wready_out,
  output logic [1:0]                s_axi_bresp_out,
  output logic                      s_axi_bvalid_out,
  input  wire logic                 s_axi_bready_in,
  input  wire logic [3:0]           s_axi_araddr_in,
  input  wire logic                 s_axi_arvalid_in,
  output logic                      s_axi_arready_out,
  output logic [31:0]               s_axi_rdata_out,
  output logic [1:0]                s_axi_rresp_out,
  output logic                      s_axi_rvalid_out,
  input  wire logic                 s_axi_rready_in,
  output logic                      flash_rd_out,
  output logic [`OBD_FA_W-1:0]      flash_addr_out,
  input  wire logic [7:0]           flash_rdata_in,
  input  wire logic                 flash_rvalid_in,
  output logic                      flash_prog_out,
  output logic [`OBD_FA_W-1:0]      flash_prog_addr_out,
  output logic [7:0]                flash_prog_data_out,
  input  wire logic                 wdt_timeout_in,
  input  wire logic                 wdt_instr_in,
  input  wire logic                 stop_mode_in,
  input  wire logic                 stop_pwrdn_in,
  input  wire logic                 stop_recovery_in,
  input  wire logic                 irq_global_en_in,
  input  wire logic                 user_prog_req_in,
  input  wire logic                 user_page_erase_req_in,
  input  wire logic                 user_mass_erase_req_in,
  input  wire logic                 dbg_mass_erase_req_in,
  output logic                      wdt_enable_out,
  output logic                      wdt_irq_out,
  output logic                      wdt_irq_ack_out,
  output logic                      short_reset_out,
  output logic [1:0]                osc_drive_select_out,
  output logic                      brownout_en_out,
  output logic                      code_access_out,
  output logic                      dbg_full_out,
  output logic                      user_write_grant_out,
  output logic                      user_mass_grant_out,
  output logic                      dbg_mass_grant_out,
  output logic                      cpu_run_out
);

  obd_state_type s_ff;
  obd_state_type nxt_s;

  logic [1:0] aw_idx;
  logic [1:0] ar_idx;
  logic       wr_go;
  logic       rd_go;
  logic       reload;
  logic       start;
  logic       stop_pd;

  assign aw_idx  = s_axi_awaddr_in[3:2];
  assign ar_idx  = s_axi_araddr_in[3:2];
  assign wr_go   = s_ff.awready & s_axi_awvalid_in & s_axi_wvalid_in;
  assign rd_go   = s_ff.arready & s_axi_arvalid_in;
  assign reload  = wr_go & (aw_idx == `OBD_IDX_CTRL) &
                   s_axi_wstrb_in[0] & s_axi_wdata_in[`OBD_C_RELOAD];
  assign start   = wdt_instr_in | (wr_go & (aw_idx == `OBD_IDX_CTRL) &
                   s_axi_wstrb_in[0] & s_axi_wdata_in[`OBD_C_WDT_START]);
  assign stop_pd = stop_mode_in & stop_pwrdn_in;

  // ==========================================================
  // next state
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.frd  = 1'b0;
    nxt_s.prog = 1'b0;
    nxt_s.ack  = 1'b0;
    nxt_s.srst = 1'b0;
    // loader: processor held until both bytes are in
    unique case (s_ff.st)
      OBD_RD_A: begin
        nxt_s.frd   = ~flash_rvalid_in;
        nxt_s.faddr = `OBD_FADDR_A;
        if (flash_rvalid_in) begin
          nxt_s.opt_a = flash_rdata_in;
          nxt_s.st    = OBD_RD_B;
        end
      end
      OBD_RD_B: begin
        nxt_s.frd   = ~flash_rvalid_in;
        nxt_s.faddr = `OBD_FADDR_B;
        if (flash_rvalid_in) begin
          nxt_s.opt_b = flash_rdata_in;
          nxt_s.st    = OBD_WAIT;
        end
      end
      OBD_WAIT: begin
        nxt_s.st  = OBD_RUN;
        nxt_s.run = 1'b1;
        // always-on start at load
        nxt_s.wdt_en = ~s_ff.opt_a[`OBD_B_ALWAYS_ON];
      end
      OBD_RUN: begin
        if (reload) begin
          nxt_s.st  = OBD_RD_A;
          nxt_s.run = 1'b0;
        end
      end
    endcase
    // decoded settings follow the latched byte
    nxt_s.cfg.osc      = nxt_s.opt_a[`OBD_B_OSC_HI:`OBD_B_OSC_LO];
    nxt_s.cfg.code_acc = nxt_s.opt_a[`OBD_B_RD_PROT];
    nxt_s.cfg.dbg_full = nxt_s.opt_a[`OBD_B_RD_PROT];
    // brown-out only dropped in stop when not kept on
    nxt_s.cfg.bo_en    = nxt_s.opt_a[`OBD_B_BO_KEEP] | ~stop_mode_in;
    // watchdog enable policy
    if (s_ff.run) begin
      if (~s_ff.opt_a[`OBD_B_ALWAYS_ON]) begin
        nxt_s.wdt_en = ~stop_pd;
      end else if (stop_recovery_in) begin
        nxt_s.wdt_en = 1'b0;
      end else if (start) begin
        nxt_s.wdt_en = 1'b1;
      end
    end
    // time-out action
    if (s_ff.run & s_ff.wdt_en & wdt_timeout_in) begin
      if (s_ff.opt_a[`OBD_B_ACTION]) begin
        nxt_s.srst = 1'b1;
      end else begin
        nxt_s.irq = 1'b1;
      end
    end
    // pending request taken only with interrupts on
    if (s_ff.irq & irq_global_en_in & ~nxt_s.srst) begin
      nxt_s.ack = 1'b1;
      // a new time-out only counts while the watchdog runs; set wins
      nxt_s.irq = s_ff.run & s_ff.wdt_en & wdt_timeout_in &
                  ~s_ff.opt_a[`OBD_B_ACTION];
    end
    // flash write gating; debug mass erase passes ungated
    nxt_s.ugrant = s_ff.run & s_ff.opt_a[`OBD_B_WR_PERMIT] &
                   (user_prog_req_in | user_page_erase_req_in);
    nxt_s.umass  = s_ff.run & s_ff.opt_a[`OBD_B_WR_PERMIT] &
                   user_mass_erase_req_in;
    nxt_s.dmass  = dbg_mass_erase_req_in;
    // ==========================================================
    // axi4-lite write: address and data taken together
    nxt_s.awready = ~s_ff.awready & ~s_ff.bvalid &
                    s_axi_awvalid_in & s_axi_wvalid_in;
    nxt_s.wready  = nxt_s.awready;
    if (s_ff.bvalid & s_axi_bready_in) begin
      nxt_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = `OBD_RESP_OKAY;
      unique case (aw_idx)
        `OBD_IDX_OPT_A, `OBD_IDX_OPT_B: begin
          // option bytes change only through a permitted flash write
          if (s_ff.run & s_ff.opt_a[`OBD_B_WR_PERMIT] &
              s_axi_wstrb_in[0]) begin
            nxt_s.prog  = 1'b1;
            nxt_s.paddr = (aw_idx == `OBD_IDX_OPT_A) ?
                          `OBD_FADDR_A : `OBD_FADDR_B;
            nxt_s.pdata = s_axi_wdata_in[7:0];
          end else begin
            nxt_s.bresp = `OBD_RESP_SLVERR;
          end
        end
        `OBD_IDX_CTRL: ;
        `OBD_IDX_STAT: nxt_s.bresp = `OBD_RESP_SLVERR;
      endcase
    end
    // ==========================================================
    // axi4-lite read
    nxt_s.arready = ~s_ff.arready & ~s_ff.rvalid & s_axi_arvalid_in;
    if (s_ff.rvalid & s_axi_rready_in) begin
      nxt_s.rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata  = 32'h0000_0000;
      unique case (ar_idx)
        `OBD_IDX_OPT_A: nxt_s.rdata[7:0] = s_ff.opt_a;
        `OBD_IDX_OPT_B: nxt_s.rdata[7:0] = s_ff.opt_b;
        `OBD_IDX_CTRL:  ;
        `OBD_IDX_STAT:  nxt_s.rdata[3:0] = {s_ff.irq, s_ff.wdt_en,
                                            s_ff.st[3], s_ff.run};
      endcase
    end
  end

  // ==========================================================
  // state register; bytes reset to erased defaults
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff          <= '0;
      s_ff.st       <= OBD_RD_A;
      s_ff.opt_a    <= `OBD_ERASED;
      s_ff.opt_b    <= `OBD_ERASED;
      s_ff.cfg.osc  <= 2'h3;
      s_ff.cfg.bo_en    <= 1'b1;
      s_ff.cfg.code_acc <= 1'b1;
      s_ff.cfg.dbg_full <= 1'b1;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  assign s_axi_awready_out    = s_ff.awready;
  assign s_axi_wready_out     = s_ff.wready;
  assign s_axi_bvalid_out     = s_ff.bvalid;
  assign s_axi_bresp_out      = s_ff.bresp;
  assign s_axi_arready_out    = s_ff.arready;
  assign s_axi_rvalid_out     = s_ff.rvalid;
  assign s_axi_rdata_out      = s_ff.rdata;
  assign s_axi_rresp_out      = `OBD_RESP_OKAY;
  assign flash_rd_out         = s_ff.frd;
  assign flash_addr_out       = s_ff.faddr;
  assign flash_prog_out       = s_ff.prog;
  assign flash_prog_addr_out  = s_ff.paddr;
  assign flash_prog_data_out  = s_ff.pdata;
  assign wdt_enable_out       = s_ff.wdt_en;
  assign wdt_irq_out          = s_ff.irq;
  assign wdt_irq_ack_out      = s_ff.ack;
  assign short_reset_out      = s_ff.srst;
  assign osc_drive_select_out = s_ff.cfg.osc;
  assign brownout_en_out      = s_ff.cfg.bo_en;
  assign code_access_out      = s_ff.cfg.code_acc;
  assign dbg_full_out         = s_ff.cfg.dbg_full;
  assign user_write_grant_out = s_ff.ugrant;
  assign user_mass_grant_out  = s_ff.umass;
  assign dbg_mass_grant_out   = s_ff.dmass;
  assign cpu_run_out          = s_ff.run;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic to_go;
  assign to_go = ce_in & s_ff.run & s_ff.wdt_en & wdt_timeout_in;

  property p_to_irq;
    to_go & ~s_ff.opt_a[`OBD_B_ACTION] |=> s_ff.irq | s_ff.ack;
  endproperty
  a_to_irq: assert property (p_to_irq) else $error("no irq");

  property p_ack_gie;
    s_ff.ack & $past(ce_in)
      |-> $past(irq_global_en_in) & $past(s_ff.irq);
  endproperty
  a_ack_gie: assert property (p_ack_gie) else $error("bad ack");

  property p_to_rst;
    to_go & s_ff.opt_a[`OBD_B_ACTION] |=> s_ff.srst & ~$past(s_ff.ack);
  endproperty
  a_to_rst: assert property (p_to_rst) else $error("no reset");

  property p_ao;
    ce_in & s_ff.run & ~s_ff.opt_a[`OBD_B_ALWAYS_ON] & ~stop_pd
      |=> s_ff.wdt_en;
  endproperty
  a_ao: assert property (p_ao) else $error("wdt off");

  property p_sw_en;
    ce_in & s_ff.run & s_ff.opt_a[`OBD_B_ALWAYS_ON] & ~s_ff.wdt_en &
      ~start |=> ~s_ff.wdt_en;
  endproperty
  a_sw_en: assert property (p_sw_en) else $error("wdt on");

  property p_osc;
    s_ff.run |-> s_ff.cfg.osc == s_ff.opt_a[5:4] &&
                 s_ff.cfg.code_acc == s_ff.opt_a[2];
  endproperty
  a_osc: assert property (p_osc) else $error("decode");

  property p_bo;
    ce_in & ~nxt_s.opt_a[3] & stop_mode_in |=> ~s_ff.cfg.bo_en;
  endproperty
  a_bo: assert property (p_bo) else $error("bo on");

  property p_fwp;
    ce_in & ~s_ff.opt_a[0] |=> ~s_ff.ugrant & ~s_ff.umass & ~s_ff.prog;
  endproperty
  a_fwp: assert property (p_fwp) else $error("write");

  sequence s_load;
    ce_in & s_ff.st == OBD_RD_A & flash_rvalid_in;
  endsequence
  property p_load;
    s_load |=> (s_ff.opt_a == $past(flash_rdata_in)) & ~s_ff.run;
  endproperty
  a_load: assert property (p_load) else $error("load");
endmodule

// ===== obd_flash_model.sv
// flash program memory model holding the two option bytes
`timescale 1ns/1ps
`include "obd_defs.svh"
module obd_flash_model (
  input  wire logic                 clk_in,
  input  wire logic                 rd_in,
  input  wire logic [`OBD_FA_W-1:0] addr_in,
  input  wire logic                 prog_in,
  input  wire logic [`OBD_FA_W-1:0] prog_addr_in,
  input  wire logic [7:0]           prog_data_in,
  input  wire logic [3:0]           slow_in,
  output logic      [7:0]           rdata_out,
  output logic                      rvalid_out
);
  // no reset input: contents survive every reset of the device
  logic [7:0] mem [2] = '{`OBD_ERASED, `OBD_ERASED};
  logic [3:0] wait_ff = 4'h0;
  initial begin
    rdata_out = 8'h00;
    rvalid_out = 1'b0;
  end
  always @(posedge clk_in) begin
    rvalid_out <= 1'b0;
    // data lines churn outside a valid cycle so stale bytes never pass
    rdata_out <= ~rdata_out;
    if (prog_in) mem[prog_addr_in[0]] <= prog_data_in;
    if (rd_in && !rvalid_out) begin
      if (wait_ff >= slow_in) begin
        rvalid_out <= 1'b1;
        rdata_out <= mem[addr_in[0]];
        wait_ff <= 4'h0;
      end else wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule

// ===== test_obd_option_byte_decoder.sv
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
`include "obd_defs.svh"
module test_obd_option_byte_decoder;
  import obd_pkg::*;
  // ==========================================================
  // signals
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, slow = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, tmo = 1'b0, instr = 1'b0;
  logic        stp = 1'b0, pwrdn = 1'b0, recov = 1'b0, gie = 1'b0, ce = 1'b1;
  logic        uprog = 1'b0, upage = 1'b0, umass = 1'b0, dmass = 1'b0;
  logic [31:0] wdata = 32'h0000_0000, rdata, r;
  logic        awready, wready, bvalid, arready, rvalid, frd, fprog, frv;
  logic        wen, irq, ack, srst, bo, cacc, dfull, ugr, umg, dmg, run;
  logic [1:0]  bresp, rresp, osc;
  logic [14:0] faddr, fpaddr;
  logic [7:0]  fpdata, frdata, a;
  logic [31:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          err_total = 0, num_checks = 0, seed = 62;
  int          n_srst = 0, n_ack = 0, n_prog = 0;
  always #50 clk = ~clk;
  obd_option_byte_decoder u_dut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .flash_rd_out(frd),
    .flash_addr_out(faddr), .flash_rdata_in(frdata),
    .flash_rvalid_in(frv), .flash_prog_out(fprog),
    .flash_prog_addr_out(fpaddr), .flash_prog_data_out(fpdata),
    .wdt_timeout_in(tmo), .wdt_instr_in(instr), .stop_mode_in(stp),
    .stop_pwrdn_in(pwrdn), .stop_recovery_in(recov),
    .irq_global_en_in(gie), .user_prog_req_in(uprog),
    .user_page_erase_req_in(upage), .user_mass_erase_req_in(umass),
    .dbg_mass_erase_req_in(dmass), .wdt_enable_out(wen),
    .wdt_irq_out(irq), .wdt_irq_ack_out(ack), .short_reset_out(srst),
    .osc_drive_select_out(osc), .brownout_en_out(bo),
    .code_access_out(cacc), .dbg_full_out(dfull),
    .user_write_grant_out(ugr), .user_mass_grant_out(umg),
    .dbg_mass_grant_out(dmg), .cpu_run_out(run));
  obd_flash_model u_flash (
    .clk_in(clk), .rd_in(frd), .addr_in(faddr), .prog_in(fprog),
    .prog_addr_in(fpaddr), .prog_data_in(fpdata), .slow_in(slow),
    .rdata_out(frdata), .rvalid_out(frv));
  // ==========================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step(inout int n);
    @(posedge clk);
    n++;
    if (n > 60) begin
      err_total++;
      $display("Error handshake expected response seen none");
      results();
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // a long hold only at power-up; hold 0 only waits out a reload
  task automatic restart(input int hold);
    int n;
    n = 0;
    if (hold > 0) begin
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (hold) @(posedge clk);
      rst_n <= 1'b1;
    end
    while (run !== 1'b1) step(n);
  endtask
  task automatic axi_wr(input logic [3:0] ad, input logic [7:0] d,
                        input logic [3:0] st, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    exp_b.push_back(er);
    r = $random(seed);
    @(posedge clk);
    awaddr <= ad;
    wdata <= {r[31:8], d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      step(n);
      if (awready === 1'b1 && !aw) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do step(n); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] ad, input logic [31:0] ex);
    int n;
    n = 0;
    exp_r.push_back(ex);
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do step(n); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // ==========================================================
  // monitor: answers are matched against the oldest note
  always @(posedge clk) begin
    if (rvalid && rready) begin
      check("rdata", rdata, exp_r.pop_front());
      check("rresp", 32'(rresp), 32'(`OBD_RESP_OKAY));
    end
    if (bvalid && bready)
      check("bresp", 32'(bresp), 32'(exp_b.pop_front()));
    n_srst += int'(srst === 1'b1);
    n_ack += int'(ack === 1'b1);
    n_prog += int'(fprog === 1'b1);
  end
  // ==========================================================
  // main sequence
  initial begin
    restart(16);
    settle(1);
    check("osc", 32'(osc), 32'h0000_0003);
    check("code", 32'(cacc & dfull & bo), 32'h0000_0001);
    check("wdt_en", 32'(wen), 32'h0000_0000);
    axi_rd(4'h4, 32'h0000_00ff);
    $display("erased defaults done");
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      a = {r[7:6], 2'(i), r[3:2], 1'b0, r[0]};
      u_flash.mem[0] = a;
      u_flash.mem[1] = 8'hff;
      slow <= 4'(3 * i);
      restart(2);
      settle(1);
      check("osc", 32'(osc), 32'(i));
      check("code", 32'(cacc), 32'(a[2]));
      check("dbg", 32'(dfull), 32'(a[2]));
      check("wdt_en", 32'(wen), 32'(!a[6]));
      check("bo", 32'(bo), 32'h0000_0001);
      @(posedge clk);
      stp <= 1'b1;
      pwrdn <= 1'b1;
      settle(3);
      check("bo stop", 32'(bo), 32'(a[3]));
      check("wdt stop", 32'(wen), 32'h0000_0000);
      @(posedge clk);
      stp <= 1'b0;
      pwrdn <= 1'b0;
      instr <= 1'b1;
      @(posedge clk);
      instr <= 1'b0;
      settle(3);
      check("wdt on", 32'(wen), 32'h0000_0001);
      n_srst = 0;
      n_ack = 0;
      @(posedge clk);
      gie <= 1'b0;
      tmo <= 1'b1;
      @(posedge clk);
      tmo <= 1'b0;
      settle(3);
      check("irq", 32'(irq), 32'(!a[7]));
      check("srst", 32'(n_srst), 32'(a[7]));
      check("ack off", 32'(n_ack), 32'h0000_0000);
      @(posedge clk);
      gie <= 1'b1;
      recov <= 1'b1;
      @(posedge clk);
      recov <= 1'b0;
      uprog <= !i[0];
      upage <= i[0];
      umass <= 1'b1;
      dmass <= 1'b1;
      settle(3);
      check("ack on", 32'(n_ack), 32'(!a[7]));
      check("irq clr", 32'(irq), 32'h0000_0000);
      check("wdt rec", 32'(wen), 32'(!a[6]));
      check("ugrant", 32'(ugr), 32'(a[0]));
      check("umass", 32'(umg), 32'(a[0]));
      check("dmass", 32'(dmg), 32'h0000_0001);
      @(posedge clk);
      {uprog, upage, umass, dmass, gie} <= 5'h00;
      n_prog = 0;
      axi_wr(4'h4, 8'hff, 4'h1, a[0] ? `OBD_RESP_OKAY : `OBD_RESP_SLVERR);
      axi_wr(4'h0, a, 4'h0, `OBD_RESP_SLVERR);
      axi_wr(4'hc, 8'h00, 4'h1, `OBD_RESP_SLVERR);
      axi_wr(4'h8, 8'h01, 4'h1, `OBD_RESP_OKAY);
      settle(1);
      check("prog", 32'(n_prog), 32'(a[0]));
      axi_rd(4'h0, 32'(a));
      axi_rd(4'h8, 32'h0000_0000);
      axi_rd(4'hc, 32'h0000_0007);
      $display("option pattern %0d done", i);
    end
    // programmed byte must survive the next reset
    u_flash.mem[0] = 8'hf5;
    restart(2);
    axi_wr(4'h0, 8'hb9, 4'h1, `OBD_RESP_OKAY);
    // latched byte stays until the next load
    axi_rd(4'h0, 32'h0000_00f5);
    axi_wr(4'h8, 8'h02, 4'h1, `OBD_RESP_OKAY);
    restart(0);
    axi_rd(4'h0, 32'h0000_00b9);
    restart(2);
    axi_rd(4'h0, 32'h0000_00b9);
    settle(1);
    check("code b9", 32'(cacc), 32'h0000_0000);
    // enable low: a time-out must not act
    n_srst = 0;
    @(posedge clk);
    ce <= 1'b0;
    tmo <= 1'b1;
    @(posedge clk);
    tmo <= 1'b0;
    settle(2);
    check("frozen", 32'(n_srst), 32'h0000_0000);
    @(posedge clk);
    ce <= 1'b1;
    $display("reprogram done");
    results();
  end
endmodule
